/* File: ptfm_pkg.sv */
// Purpose: Shared constants and carriers for the paper tape feed monitor
// Assumes: 100 MHz system clock, 32-bit classic Wishbone register access
// Notes: Times are kept in their own unit, cycle counts derived from them
package ptfm_pkg;

   // Clock
   localparam int CLK_PERIOD_NS = 10;

   // Times as specified
   localparam int STROBE_TIME_NS = 250;
   localparam int BLANK_TIME_US = 7000;
   localparam int INTERVAL_TIME_US = 3500;
   localparam int GUARD_TIME_US = 2000;
   localparam int HOLDOFF_TIME_US = 3000;

   // Derived cycle counts
   localparam int STROBE_CYCLES = (STROBE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int BLANK_CYCLES = (BLANK_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int INTERVAL_CYCLES = (INTERVAL_TIME_US * 1000) / CLK_PERIOD_NS;
   localparam int GUARD_CYCLES = (GUARD_TIME_US * 1000) / CLK_PERIOD_NS;
   localparam int HOLDOFF_CYCLES = (HOLDOFF_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Widths
   localparam int FRAME_WIDTH = 7;
   localparam int CTRL_WIDTH = 18;
   localparam int ADDR_WIDTH = 8;
   localparam int DATA_WIDTH = 32;
   localparam int SEL_WIDTH = 4;
   localparam int EV_WIDTH = 3;
   localparam int BOOT_ADDR_WIDTH = 15;

   // Control register bits
   localparam int CTRL_SELECT_BIT = 17;
   localparam int CTRL_START_BIT = 16;
   localparam int CTRL_STOP_BIT = 15;

   // Register offsets
   localparam logic [ADDR_WIDTH-1:0] OFS_CONTROL = 8'h00;
   localparam logic [ADDR_WIDTH-1:0] OFS_INPUT = 8'h04;
   localparam logic [ADDR_WIDTH-1:0] OFS_STATUS = 8'h08;
   localparam logic [ADDR_WIDTH-1:0] OFS_MASK = 8'h0c;
   localparam logic [ADDR_WIDTH-1:0] OFS_STATE = 8'h10;
   localparam logic [ADDR_WIDTH-1:0] OFS_COMMAND = 8'h14;

   // Event bits of status and mask
   localparam int EV_FRAME_BIT = 0;
   localparam int EV_RESUME_BIT = 1;
   localparam int EV_FAULT_BIT = 2;

   // State register bits
   localparam int STATE_TAPE_FEED_BIT = 0;
   localparam int STATE_HALT_BIT = 1;
   localparam int STATE_BLANK_BIT = 2;
   localparam int STATE_HOLDOFF_BIT = 3;
   localparam int STATE_INTERVAL_BIT = 4;
   localparam int STATE_GUARD_BIT = 5;
   localparam int STATE_FAULT_BIT = 6;
   localparam int STATE_DETECT_BIT = 7;
   localparam int STATE_PENDING_BIT = 8;

   // Command register bits
   localparam int CMD_FAULT_CLEAR_BIT = 0;
   localparam int CMD_BOOT_BIT = 1;

   // Reset values
   localparam logic [CTRL_WIDTH-1:0] CTRL_RESET = 18'h00000;
   localparam logic [FRAME_WIDTH-1:0] INPUT_RESET = 7'h00;
   localparam logic [EV_WIDTH-1:0] MASK_RESET = 3'h0;
   localparam logic [BOOT_ADDR_WIDTH-1:0] BOOT_ADDR = 15'h0000;

   // Wishbone carriers
   typedef struct packed
   {
      logic cyc;
      logic stb;
      logic we;
      logic [ADDR_WIDTH-1:0] adr;
      logic [SEL_WIDTH-1:0] sel;
      logic [DATA_WIDTH-1:0] dat;
   } ptfm_wb_req_t;

   typedef struct packed
   {
      logic ack;
      logic [DATA_WIDTH-1:0] dat;
   } ptfm_wb_rsp_t;

   // Reader pins
   typedef struct packed
   {
      logic feed_n;
      logic [FRAME_WIDTH-1:0] levels;
   } ptfm_tape_in_t;

endpackage

/* File: ptfm_timer.sv */
// Purpose: Retriggerable interval timer counted in system clocks
// Assumes: trig_i is a one-cycle pulse in the clk_i domain
// Notes: expire_o pulses in the last active cycle unless retriggered
`timescale 1ns/1ps
`default_nettype none

module ptfm_timer
#(
   parameter int COUNT = 16,
   parameter int W = $clog2(COUNT + 1)
)
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic trig_i,
   output logic active_o,
   output logic expire_o
);
   import ptfm_pkg::*;

   typedef struct packed
   {
      logic [W-1:0] cnt;
   } ptfm_timer_state_t;

   ptfm_timer_state_t state_reg;
   ptfm_timer_state_t state_next;

   always_comb
   begin
      state_next = state_reg;
      if (trig_i)
      begin
         state_next.cnt = W'(COUNT);
      end
      else if (state_reg.cnt != '0)
      begin
         state_next.cnt = state_reg.cnt - W'(1);
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state_reg <= '0;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   assign active_o = (state_reg.cnt != '0);
   assign expire_o = (state_reg.cnt == W'(1)) && !trig_i;

endmodule

`default_nettype wire

/* File: ptfm_core.sv */
// Purpose: Paper tape reader feed monitor with frame capture and fault watch
// Assumes: Feed and level pins are asynchronous; gated_pulse_i is on clk_i
// Notes: Registers over classic Wishbone; timers count system clocks
// Notes on behaviour
// - Strobe on rising trailing edge of feed
// - Strobe is one quarter microsecond pulse
// - Control operation feed clears control, resumes
// - Reading feed samples, clocks detector, acknowledges
// - Holes set low seven bits of cleared register
// - Missing feed registers fault, shows indication
// - Detection blanked seven milliseconds after start
// - Blanking started by pulse with bits 17,16
// - Stop pulse sets halt; feed clears tape feed
// - Detect only when blank expired and feeding
// - Feed retriggers 3.5 millisecond interval timer
// - Interval expiry starts guard timer at once
// - Pulses arriving keep fault from arising
// - Fault declared at guard end, interval idle
// - Fault halts computer and reader, lights both
// - Boot loads and jumps to address zero
// - Stop feed starts hold-off, clears both flags
// - Step sets both flags, one frame delivered
`timescale 1ns/1ps
`default_nettype none

module ptfm_core
#(
   parameter int BLANK_COUNT = ptfm_pkg::BLANK_CYCLES,
   parameter int INTERVAL_COUNT = ptfm_pkg::INTERVAL_CYCLES,
   parameter int GUARD_COUNT = ptfm_pkg::GUARD_CYCLES,
   parameter int HOLDOFF_COUNT = ptfm_pkg::HOLDOFF_CYCLES
)
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire ptfm_pkg::ptfm_wb_req_t wb_req_i,
   output ptfm_pkg::ptfm_wb_rsp_t wb_rsp_o,
   input wire ptfm_pkg::ptfm_tape_in_t tape_i,
   input wire logic gated_pulse_i,
   output logic sample_strobe_o,
   output logic [ptfm_pkg::FRAME_WIDTH-1:0] input_register_o,
   output logic frame_read_ack_o,
   output logic clear_control_register_o,
   output logic control_resume_o,
   output logic clutch_o,
   output logic brake_o,
   output logic lost_sprocket_indication_o,
   output logic general_fault_o,
   output logic halt_computer_o,
   output logic boot_start_o,
   output logic [ptfm_pkg::BOOT_ADDR_WIDTH-1:0] boot_addr_o,
   output logic irq_o
);
   import ptfm_pkg::*;

   typedef struct packed
   {
      logic feed_s1;
      logic feed_s2;
      logic feed_s3;
      logic [FRAME_WIDTH-1:0] lvl_s1;
      logic [FRAME_WIDTH-1:0] lvl_s2;
      logic [CTRL_WIDTH-1:0] ctrl;
      logic [FRAME_WIDTH-1:0] input_reg;
      logic tape_feed;
      logic halt;
      logic pending;
      logic fault;
      logic [EV_WIDTH-1:0] status;
      logic [EV_WIDTH-1:0] mask;
      logic ack;
      logic [DATA_WIDTH-1:0] rdat;
      logic resume;
      logic read_ack;
      logic boot;
   } ptfm_state_t;

   ptfm_state_t state_reg;
   ptfm_state_t state_next;

   logic feed_edge;
   logic pulse_ok;
   logic blank_trig;
   logic holdoff_trig;
   logic blank_active;
   logic holdoff_active;
   logic interval_active;
   logic interval_expire;
   logic guard_active;
   logic guard_expire;
   logic strobe_active;
   logic detect_en;
   logic fault_event;
   logic reading;
   logic wb_req;
   logic wb_write;
   logic wb_read;
   logic [DATA_WIDTH-1:0] wmask;
   logic [DATA_WIDTH-1:0] state_word;

   // Byte enables widened to a bit mask
   genvar gi;
   generate
      for (gi = 0; gi < SEL_WIDTH; gi++)
      begin : g_mask
         assign wmask[gi*8 +: 8] = {8{wb_req_i.sel[gi]}};
      end
   endgenerate

   // Trailing edge of the active-low feed hole pulse
   assign feed_edge = state_reg.feed_s2 && !state_reg.feed_s3;
   assign reading = state_reg.tape_feed && !state_reg.fault;
   assign pulse_ok = gated_pulse_i && !holdoff_active && state_reg.ctrl[CTRL_SELECT_BIT];
   assign blank_trig = pulse_ok && state_reg.ctrl[CTRL_START_BIT];
   assign holdoff_trig = feed_edge && state_reg.halt && !state_reg.fault;
   assign detect_en = !blank_active && state_reg.tape_feed;
   assign fault_event = detect_en && guard_expire && !interval_active;

   assign wb_req = wb_req_i.cyc && wb_req_i.stb && !state_reg.ack;
   assign wb_write = wb_req && wb_req_i.we;
   assign wb_read = wb_req && !wb_req_i.we;

   always_comb
   begin
      state_word = '0;
      state_word[STATE_TAPE_FEED_BIT] = state_reg.tape_feed;
      state_word[STATE_HALT_BIT] = state_reg.halt;
      state_word[STATE_BLANK_BIT] = blank_active;
      state_word[STATE_HOLDOFF_BIT] = holdoff_active;
      state_word[STATE_INTERVAL_BIT] = interval_active;
      state_word[STATE_GUARD_BIT] = guard_active;
      state_word[STATE_FAULT_BIT] = state_reg.fault;
      state_word[STATE_DETECT_BIT] = detect_en;
      state_word[STATE_PENDING_BIT] = state_reg.pending;
   end

   // Sampling strobe, quarter microsecond
   ptfm_timer #(.COUNT(STROBE_CYCLES)) u_strobe
   (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .trig_i(feed_edge && reading),
      .active_o(strobe_active),
      .expire_o()
   );

   // Start blanking
   ptfm_timer #(.COUNT(BLANK_COUNT)) u_blank
   (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .trig_i(blank_trig),
      .active_o(blank_active),
      .expire_o()
   );

   // Interval timer retriggered by each feed while reading
   ptfm_timer #(.COUNT(INTERVAL_COUNT)) u_interval
   (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .trig_i(feed_edge && reading),
      .active_o(interval_active),
      .expire_o(interval_expire)
   );

   // Guard timer launched in the interval's last active cycle
   ptfm_timer #(.COUNT(GUARD_COUNT)) u_guard
   (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .trig_i(interval_expire),
      .active_o(guard_active),
      .expire_o(guard_expire)
   );

   // Hold-off after a completed stop
   ptfm_timer #(.COUNT(HOLDOFF_COUNT)) u_holdoff
   (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .trig_i(holdoff_trig),
      .active_o(holdoff_active),
      .expire_o()
   );

   always_comb
   begin
      state_next = state_reg;
      state_next.resume = 1'b0;
      state_next.read_ack = 1'b0;
      state_next.boot = 1'b0;
      state_next.ack = 1'b0;

      // Two-stage synchronisers
      state_next.feed_s1 = tape_i.feed_n;
      state_next.feed_s2 = state_reg.feed_s1;
      state_next.feed_s3 = state_reg.feed_s2;
      state_next.lvl_s1 = tape_i.levels;
      state_next.lvl_s2 = state_reg.lvl_s1;

      // Gated clock pulse selects start, stop or step
      if (pulse_ok && !state_reg.fault)
      begin
         if (state_reg.ctrl[CTRL_START_BIT] && !state_reg.tape_feed && !state_reg.halt)
         begin
            state_next.tape_feed = 1'b1;
            state_next.pending = 1'b1;
            if (state_reg.ctrl[CTRL_STOP_BIT])
            begin
               state_next.halt = 1'b1;
            end
         end
         else if (state_reg.ctrl[CTRL_STOP_BIT] && !state_reg.ctrl[CTRL_START_BIT]
                  && state_reg.tape_feed && !state_reg.halt)
         begin
            state_next.halt = 1'b1;
            state_next.pending = 1'b1;
         end
      end

      // Feed pulse actions
      if (feed_edge && !state_reg.fault)
      begin
         if (state_reg.tape_feed)
         begin
            state_next.input_reg = state_reg.lvl_s2;
            state_next.read_ack = 1'b1;
         end
         if (state_reg.pending || state_reg.halt)
         begin
            state_next.ctrl = CTRL_RESET;
            state_next.resume = 1'b1;
            state_next.pending = 1'b0;
         end
         if (state_reg.halt)
         begin
            state_next.halt = 1'b0;
            state_next.tape_feed = 1'b0;
         end
      end

      // Missing feed fault latches
      if (fault_event)
      begin
         state_next.fault = 1'b1;
      end

      // Register writes
      if (wb_write)
      begin
         case (wb_req_i.adr)
            OFS_CONTROL:
            begin
               state_next.ctrl = CTRL_WIDTH'((state_reg.ctrl & ~wmask[CTRL_WIDTH-1:0])
                                 | (wb_req_i.dat[CTRL_WIDTH-1:0] & wmask[CTRL_WIDTH-1:0]));
            end
            OFS_MASK:
            begin
               if (wb_req_i.sel[0])
               begin
                  state_next.mask = wb_req_i.dat[EV_WIDTH-1:0];
               end
            end
            OFS_COMMAND:
            begin
               if (wb_req_i.sel[0] && wb_req_i.dat[CMD_FAULT_CLEAR_BIT])
               begin
                  state_next.fault = fault_event; // A new fault outlives the clear
                  state_next.tape_feed = 1'b0;
                  state_next.halt = 1'b0;
                  state_next.pending = 1'b0;
                  state_next.ctrl = CTRL_RESET;
               end
               if (wb_req_i.sel[0] && wb_req_i.dat[CMD_BOOT_BIT])
               begin
                  state_next.boot = 1'b1;
               end
            end
            default:
            begin
               state_next.ctrl = state_next.ctrl;
            end
         endcase
      end

      // Register reads
      if (wb_req)
      begin
         state_next.ack = 1'b1;
         state_next.rdat = '0;
      end
      if (wb_read)
      begin
         case (wb_req_i.adr)
            OFS_CONTROL: state_next.rdat = DATA_WIDTH'(state_reg.ctrl);
            OFS_INPUT: state_next.rdat = DATA_WIDTH'(state_reg.input_reg);
            OFS_STATUS: state_next.rdat = DATA_WIDTH'(state_reg.status);
            OFS_MASK: state_next.rdat = DATA_WIDTH'(state_reg.mask);
            OFS_STATE: state_next.rdat = state_word;
            default: state_next.rdat = '0;
         endcase
      end

      // Sticky events; a new event outlives a clearing read
      state_next.status = state_reg.status;
      if (wb_read && wb_req_i.adr == OFS_STATUS)
      begin
         state_next.status = '0;
      end
      if (feed_edge && reading)
      begin
         state_next.status[EV_FRAME_BIT] = 1'b1;
      end
      if (feed_edge && !state_reg.fault && (state_reg.pending || state_reg.halt))
      begin
         state_next.status[EV_RESUME_BIT] = 1'b1;
      end
      if (fault_event)
      begin
         state_next.status[EV_FAULT_BIT] = 1'b1;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state_reg <= '0;
         state_reg.feed_s1 <= 1'b1;
         state_reg.feed_s2 <= 1'b1;
         state_reg.feed_s3 <= 1'b1;
         state_reg.ctrl <= CTRL_RESET;
         state_reg.input_reg <= INPUT_RESET;
         state_reg.mask <= MASK_RESET;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   assign wb_rsp_o.ack = state_reg.ack;
   assign wb_rsp_o.dat = state_reg.rdat;
   assign sample_strobe_o = strobe_active;
   assign input_register_o = state_reg.input_reg;
   assign frame_read_ack_o = state_reg.read_ack;
   assign clear_control_register_o = state_reg.resume;
   assign control_resume_o = state_reg.resume;
   assign clutch_o = state_reg.tape_feed && !state_reg.fault;
   assign brake_o = !(state_reg.tape_feed && !state_reg.fault);
   assign lost_sprocket_indication_o = state_reg.fault;
   assign general_fault_o = state_reg.fault;
   assign halt_computer_o = state_reg.fault;
   assign boot_start_o = state_reg.boot;
   assign boot_addr_o = BOOT_ADDR;
   assign irq_o = |(state_reg.status & state_reg.mask);

endmodule

`default_nettype wire

/* File: ptfm_sva.sv */
// Purpose: Port assertions for the feed monitor
// Assumes: One clk_i domain, rst_i synchronous active high
// Notes: Timer counts come in through the bind
`timescale 1ns/1ps
`default_nettype none

module ptfm_sva
import ptfm_pkg::*;
#(
   parameter int INTERVAL_COUNT = 100,
   parameter int GUARD_COUNT = 60
)
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire ptfm_pkg::ptfm_wb_req_t wb_req_i,
   input wire ptfm_pkg::ptfm_wb_rsp_t wb_rsp_o,
   input wire ptfm_pkg::ptfm_tape_in_t tape_i,
   input wire logic sample_strobe_o,
   input wire logic [ptfm_pkg::FRAME_WIDTH-1:0] input_register_o,
   input wire logic frame_read_ack_o,
   input wire logic clear_control_register_o,
   input wire logic control_resume_o,
   input wire logic clutch_o,
   input wire logic brake_o,
   input wire logic lost_sprocket_indication_o,
   input wire logic general_fault_o,
   input wire logic halt_computer_o,
   input wire logic boot_start_o,
   input wire logic [ptfm_pkg::BOOT_ADDR_WIDTH-1:0] boot_addr_o
);
   logic [5:0] hi_len_reg;
   logic [19:0] gap_reg;
   default clocking dflt_cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   // Strobe length and cycles since the last strobe
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         hi_len_reg <= 6'h00;
         gap_reg <= 20'h00000;
      end
      else
      begin
         hi_len_reg <= sample_strobe_o ? hi_len_reg + 6'h01 : 6'h00;
         gap_reg <= $rose(sample_strobe_o) ? 20'h00000 : gap_reg + {19'h00000, ~&gap_reg};
      end
   end

   a_strobe_edge: assert property (
      $rose(sample_strobe_o) |-> $past(tape_i.feed_n) && !$past(tape_i.feed_n, 6))
      else $error("strobe not after feed trailing edge");
   a_strobe_width: assert property (
      $fell(sample_strobe_o) |-> hi_len_reg == 6'h19)
      else $error("strobe width wrong");
   a_resume_pair: assert property (
      control_resume_o |-> clear_control_register_o && $rose(sample_strobe_o)
      ##1 !control_resume_o)
      else $error("resume not a single pulse with clear");
   a_ack_strobe: assert property (
      frame_read_ack_o |-> $rose(sample_strobe_o) ##1 !frame_read_ack_o)
      else $error("read ack not tied to strobe");
   a_frame_value: assert property (
      frame_read_ack_o |-> input_register_o == $past(tape_i.levels, 2))
      else $error("frame value wrong");
   a_fault_holds: assert property (
      general_fault_o && !(wb_req_i.cyc && wb_req_i.stb && wb_req_i.we) |=> general_fault_o)
      else $error("fault dropped without clear");
   a_brake_clutch: assert property (
      (brake_o != clutch_o)
      && (!$fell(clutch_o) || general_fault_o || control_resume_o
          || ($past(wb_req_i.cyc) && $past(wb_req_i.stb) && $past(wb_req_i.we))))
      else $error("brake or clutch changed without a feed stop");
   a_fault_gap: assert property (
      $rose(general_fault_o) |-> gap_reg >= INTERVAL_COUNT + GUARD_COUNT - 4)
      else $error("fault raised too early");
   a_fault_lamps: assert property (
      general_fault_o |-> lost_sprocket_indication_o && halt_computer_o && brake_o)
      else $error("fault outputs inconsistent");
   a_boot_zero: assert property (
      boot_start_o |-> boot_addr_o == 15'h0000 ##1 !boot_start_o)
      else $error("boot start wrong");
   a_bus_answer: assert property (
      wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack |=> wb_rsp_o.ack ##1 !wb_rsp_o.ack)
      else $error("bus ack timing wrong");
endmodule

bind ptfm_core ptfm_sva #(.INTERVAL_COUNT(INTERVAL_COUNT), .GUARD_COUNT(GUARD_COUNT)) u_sva (
   .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i), .wb_rsp_o(wb_rsp_o), .tape_i(tape_i),
   .sample_strobe_o(sample_strobe_o), .input_register_o(input_register_o),
   .frame_read_ack_o(frame_read_ack_o), .clear_control_register_o(clear_control_register_o),
   .control_resume_o(control_resume_o), .clutch_o(clutch_o), .brake_o(brake_o),
   .lost_sprocket_indication_o(lost_sprocket_indication_o), .general_fault_o(general_fault_o),
   .halt_computer_o(halt_computer_o), .boot_start_o(boot_start_o), .boot_addr_o(boot_addr_o));
`default_nettype wire

/* File: ptfm_reader_model.sv */
// Purpose: Behavioural tape reader feeding frames on its own clock
// Assumes: Sixteen link ticks per frame, feed low for two ticks
// Notes: skip_i suppresses feed holes to provoke a missing pulse
`timescale 1ns/1ps
`default_nettype none

module ptfm_reader_model
import ptfm_pkg::*;
(
   input wire logic lclk_i,
   input wire logic clutch_i,
   input wire logic skip_i,
   output var ptfm_pkg::ptfm_tape_in_t tape_o,
   output var logic [ptfm_pkg::FRAME_WIDTH-1:0] frame_o
);
   logic [3:0] ph_reg;

   initial
   begin
      ph_reg = 4'h0;
      frame_o = 7'h05;
      tape_o = '{feed_n: 1'b1, levels: 7'h7a};
   end

   // Tape moves only while the clutch is engaged
   always @(posedge lclk_i)
   begin
      if (clutch_i === 1'b1)
      begin
         ph_reg <= ph_reg + 4'h1;
         if (ph_reg == 4'h0)
         begin
            frame_o <= frame_o + 7'h13;
            tape_o.levels <= frame_o + 7'h13;
         end
         if (ph_reg == 4'h2)
            tape_o.feed_n <= skip_i;
         if (ph_reg == 4'h4)
            tape_o.feed_n <= 1'b1;
         // Levels no longer valid once past the hole
         if (ph_reg == 4'h6)
            tape_o.levels <= ~frame_o;
      end
   end
endmodule
`default_nettype wire

/* File: tb_top.sv */
// Purpose: Directed bench for the feed monitor
// Assumes: Short timer counts, reader model on an 80 ns link clock
// Notes: Bus tasks run classic Wishbone single cycles
`timescale 1ns/1ps
`default_nettype none

module tb_top;
   import ptfm_pkg::*;
   localparam logic [31:0] RUN = 32'h30000;
   localparam logic [31:0] STOP = 32'h28000;
   localparam logic [31:0] STEP = 32'h38000;
   logic clk_i = 1'b0;
   logic lclk = 1'b0;
   logic rst_i = 1'b1;
   logic gated_pulse_i = 1'b0;
   logic skip = 1'b0;
   ptfm_wb_req_t wb_req = '0;
   ptfm_wb_rsp_t wb_rsp;
   ptfm_tape_in_t tape;
   logic [FRAME_WIDTH-1:0] frame;
   logic [FRAME_WIDTH-1:0] in_reg;
   logic ack, res, clutch, brake, lost, gfault, boot, irq;
   logic [31:0] rd;
   int n_mismatch = 0;
   int checks_done = 0;
   int n_ack = 0;
   int n_res = 0;
   int n_boot = 0;
   int k;

   always #5 clk_i = ~clk_i;
   always #40 lclk = ~lclk;

   ptfm_core #(.BLANK_COUNT(400), .INTERVAL_COUNT(100), .GUARD_COUNT(60), .HOLDOFF_COUNT(80))
   u_dut (
      .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req), .wb_rsp_o(wb_rsp), .tape_i(tape),
      .gated_pulse_i(gated_pulse_i), .sample_strobe_o(), .input_register_o(in_reg),
      .frame_read_ack_o(ack), .clear_control_register_o(), .control_resume_o(res),
      .clutch_o(clutch), .brake_o(brake), .lost_sprocket_indication_o(lost),
      .general_fault_o(gfault), .halt_computer_o(), .boot_start_o(boot), .boot_addr_o(),
      .irq_o(irq));

   ptfm_reader_model u_reader (
      .lclk_i(lclk), .clutch_i(clutch), .skip_i(skip), .tape_o(tape), .frame_o(frame));

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hf, dat: d};
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (wb_rsp.ack !== 1'b1 && n < 50);
      if (n >= 50)
         n_mismatch++;
      rd = wb_rsp.dat;
      wb_req <= '0;
      @(posedge clk_i);
   endtask

   task automatic gp();
      gated_pulse_i <= 1'b1;
      @(posedge clk_i);
      gated_pulse_i <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic till(ref int c, input int lim);
      int n;
      n = 0;
      while (c < lim && n < 5000)
      begin
         @(posedge clk_i);
         n++;
      end
      if (c < lim)
         n_mismatch++;
   endtask

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // Event counters and frame contents
   always @(posedge clk_i)
   begin
      n_boot <= n_boot + (boot === 1'b1);
      n_res <= n_res + (res === 1'b1);
      if (ack === 1'b1)
      begin
         n_ack <= n_ack + 1;
         chk("frame", {25'h0, in_reg}, {25'h0, frame});
      end
   end

   initial
   begin
      #500000;
      n_mismatch++;
      end_of_test();
   end

   initial
   begin
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      chk("brake", brake, 1'b1);
      chk("irq", irq, 1'b0);
      wb(0, OFS_MASK, 0);
      chk("mask", rd, 0);
      wb(1, 8'h3c, 32'hffffffff);
      wb(0, 8'h3c, 0);
      chk("unmapped", rd, 0);
      wb(1, OFS_INPUT, 32'hffffffff);
      wb(0, OFS_INPUT, 0);
      chk("input", rd, 0);
      // Free run
      wb(1, OFS_CONTROL, RUN);
      gp();
      wb(0, OFS_STATE, 0);
      chk("blank", rd[STATE_BLANK_BIT], 1'b1);
      chk("clutch", clutch, 1'b1);
      till(n_res, 1);
      wb(0, OFS_CONTROL, 0);
      chk("control", rd, 0);
      till(n_ack, n_ack + 6);
      wb(0, OFS_STATE, 0);
      chk("detect", rd[STATE_DETECT_BIT], 1'b1);
      chk("fault", gfault, 1'b0);
      // Stop just after a frame, then try a start inside the hold-off
      k = n_ack;
      till(n_ack, k + 1);
      wb(1, OFS_CONTROL, STOP);
      gp();
      wb(0, OFS_STATE, 0);
      chk("halt", rd[STATE_HALT_BIT], 1'b1);
      till(n_res, 2);
      chk("clutch", clutch, 1'b0);
      wb(0, OFS_STATE, 0);
      chk("state", rd[3:0], 4'h8);
      wb(1, OFS_CONTROL, RUN);
      gp();
      wb(0, OFS_STATE, 0);
      chk("blocked", rd[STATE_TAPE_FEED_BIT], 1'b0);
      repeat (100) @(posedge clk_i);
      wb(1, OFS_MASK, 1);
      chk("irq", irq, 1'b1);
      wb(1, OFS_MASK, 0);
      chk("irq", irq, 1'b0);
      wb(1, OFS_MASK, 1);
      wb(0, OFS_STATUS, 0);
      chk("status", rd[EV_FRAME_BIT], 1'b1);
      chk("irq", irq, 1'b0);
      // Step delivers one frame
      k = n_ack;
      wb(1, OFS_CONTROL, STEP);
      gp();
      till(n_res, 3);
      repeat (300) @(posedge clk_i);
      chk("frames", n_ack - k, 1);
      // Missing pulses inside and after blanking
      wb(1, OFS_CONTROL, RUN);
      gp();
      till(n_res, 4);
      skip <= 1'b1;
      repeat (400) @(posedge clk_i);
      chk("fault", gfault, 1'b0);
      skip <= 1'b0;
      till(n_ack, n_ack + 3);
      skip <= 1'b1;
      k = 0;
      while (gfault !== 1'b1 && k < 1000)
      begin
         @(posedge clk_i);
         k++;
      end
      chk("fault", gfault, 1'b1);
      chk("lamp", lost, 1'b1);
      chk("brake", brake, 1'b1);
      wb(1, OFS_MASK, 4);
      chk("irq", irq, 1'b1);
      wb(0, OFS_STATUS, 0);
      chk("status", rd[EV_FAULT_BIT], 1'b1);
      skip <= 1'b0;
      wb(1, OFS_COMMAND, 1);
      chk("fault", gfault, 1'b0);
      wb(1, OFS_COMMAND, 2);
      @(posedge clk_i);
      chk("boot", n_boot, 1);
      end_of_test();
   end
endmodule
`default_nettype wire
